// [rtl/scss_top.sv]
`timescale 1ns/10ps
module scss_top
    import scss_pkg::*;
(
    input  wire logic        pclk,         // Bus clock, 50 MHz
    input  wire logic        presetn,      // Asynchronous reset, active low
    input  wire logic        ce,           // Clock enable, freezes all state
    input  wire logic        psel,         // APB select
    input  wire logic        penable,      // APB enable
    input  wire logic        pwrite,       // APB direction
    input  wire logic [11:0] paddr,        // APB byte address
    input  wire logic [31:0] pwdata,       // APB write data
    output logic      [31:0] prdata,       // APB read data
    output logic             pready,       // APB ready
    output logic             pslverr,      // APB error, unmapped address
    input  wire logic        hxt_osc_in,   // Fast crystal oscillator output
    input  wire logic        int_fast_rc_osc_osc_in,  // Fast RC oscillator output
    input  wire logic        lxt_osc_in,   // Slow crystal oscillator output
    input  wire logic        int_slow_rc_osc_osc_in,  // Slow RC oscillator output
    input  wire logic        cpu_halt,     // CPU halted, sleep or idle
    output logic             sys_clk_en,   // System clock enable pulse
    output logic             wdt_clk_en,   // Watchdog clock enable pulse
    output logic             tb_clk_en,    // Time base clock enable pulse
    output logic             hxt_en,       // Fast crystal oscillator enable
    output logic             int_fast_rc_osc_en,      // Fast RC oscillator enable
    output logic      [1:0]  int_fast_rc_osc_freq,    // Fast RC frequency trim select
    output logic             lxt_en,       // Slow crystal oscillator enable
    output logic             xt_pins_osc   // Slow crystal pins in oscillator mode
);
    logic [7:0]  scc_reg;
    logic [3:0]  int_fast_rc_control_reg_reg;
    logic [2:0]  lxtc_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;
    logic [9:0]  lxt_cnt_reg;
    logic        lxt_rdy_reg;
    logic [2:0]  act_cks_reg;
    logic        act_fhs_reg;
    logic        act_fss_reg;
    logic        sync_reg;
    logic [5:0]  cnt_reg;
    logic        sys_en_reg;
    logic        wdt_en_reg;
    logic        tb_en_reg;
    logic        hxt_en_reg;
    logic        int_fast_rc_osc_en_reg;
    logic        lxt_en_reg;

    logic hxt_tick;
    logic int_fast_rc_osc_tick;
    logic lxt_tick;
    logic int_slow_rc_osc_tick;

    scss_osc_tick u_hxt  (.pclk(pclk), .presetn(presetn), .ce(ce),
                          .osc_in(hxt_osc_in),  .tick(hxt_tick));
    scss_osc_tick u_int_fast_rc_osc (.pclk(pclk), .presetn(presetn), .ce(ce),
                          .osc_in(int_fast_rc_osc_osc_in), .tick(int_fast_rc_osc_tick));
    scss_osc_tick u_lxt  (.pclk(pclk), .presetn(presetn), .ce(ce),
                          .osc_in(lxt_osc_in),  .tick(lxt_tick));
    scss_osc_tick u_int_slow_rc_osc (.pclk(pclk), .presetn(presetn), .ce(ce),
                          .osc_in(int_slow_rc_osc_osc_in), .tick(int_slow_rc_osc_tick));

    // Bus decode.
    wire        access    = psel & penable & pready_reg;
    wire        wr_en     = access & pwrite;
    wire        hit_scc   = paddr == SCSS_SCC_OFF;
    wire        hit_int_fast_rc_control_reg = paddr == SCSS_INT_FAST_RC_CONTROL_REG_OFF;
    wire        hit_lxtc  = paddr == SCSS_LXTC_OFF;
    wire        hit_stat  = paddr == SCSS_STAT_OFF;
    wire        mapped    = hit_scc | hit_int_fast_rc_control_reg | hit_lxtc | hit_stat;

    wire [2:0]  cks      = scc_reg[SCSS_CKS_LSB +: 3];
    wire        fast_source_select      = scc_reg[SCSS_FHS_BIT];
    wire        slow_source_select      = scc_reg[SCSS_FSS_BIT];
    wire        fhiden   = scc_reg[SCSS_FHIDEN_BIT];
    wire        fsiden   = scc_reg[SCSS_FSIDEN_BIT];
    wire [1:0]  wr_hfreq = pwdata[SCSS_HFREQ_LSB +: 2];

    // The unused code is refused so only three frequencies exist
    wire [1:0]  hfreq_next = (wr_hfreq == SCSS_HFREQ_BAD) ?
                             int_fast_rc_control_reg_reg[SCSS_HFREQ_LSB +: 2] : wr_hfreq;
    wire [3:0]  int_fast_rc_control_reg_next = {hfreq_next, 1'b0, pwdata[SCSS_HIRCEN_BIT]};

    // Slow crystal runs only while its pins serve the oscillator
    wire        lxt_run  = lxtc_reg[SCSS_SLOW_CRYSTAL_ENABLE_BIT] & lxtc_reg[SCSS_XTPIN_BIT];

    // Slow crystal counts as selected only once it is usable
    wire        fss_eff  = slow_source_select & lxt_rdy_reg;
    wire        pending  = {cks, fast_source_select, fss_eff} != {act_cks_reg, act_fhs_reg, act_fss_reg};

    wire        fh_tick  = (act_fhs_reg == SCSS_FAST_HXT) ? hxt_tick : int_fast_rc_osc_tick;
    // Slow path source, falling back to the RC if the crystal drops
    wire        fsub_lxt  = (act_fss_reg == SCSS_SLOW_LXT) & lxt_rdy_reg;
    wire        fsub_tick = fsub_lxt ? lxt_tick : int_slow_rc_osc_tick;

    wire        slow_mode = act_cks_reg == SCSS_CKS_SLOW;
    wire        src_tick  = slow_mode ? fsub_tick : fh_tick;
    // Ratio two to the power of the select field, except slow mode which divides by one
    wire [6:0]  div_full  = (7'h01 << act_cks_reg) - 7'h01;
    wire [5:0]  div_mask  = slow_mode ? 6'h00 : div_full[5:0];
    wire        div_wrap  = cnt_reg == div_mask;
    wire        sys_pulse = src_tick & ~sync_reg & div_wrap;
    // Switch only on a period boundary between source ticks
    wire        apply_sw  = pending & (cnt_reg == 6'h00) & ~src_tick;

    wire        fast_keep = ~cpu_halt | fhiden;
    wire        slow_keep = ~cpu_halt | fsiden;

    wire [31:0] rd_data = hit_scc   ? {24'h000000, scc_reg} :
                          hit_int_fast_rc_control_reg ? {28'h0000000, int_fast_rc_control_reg_reg} :
                          hit_lxtc  ? {29'h0, lxtc_reg[2], lxt_rdy_reg, lxtc_reg[0]} :
                          hit_stat  ? {24'h000000, act_cks_reg, 1'b0, act_fhs_reg,
                                       act_fss_reg, sync_reg, pending} :
                                      32'h00000000;

    // APB slave: ready in the second access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end
        else if (ce)
        begin
            pready_reg  <= psel & penable & ~pready_reg;
            pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
            prdata_reg  <= (psel & penable & ~pready_reg & ~pwrite) ? rd_data : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scc_reg   <= SCSS_SCC_RST;
            int_fast_rc_control_reg_reg <= SCSS_INT_FAST_RC_CONTROL_REG_RST;
            lxtc_reg  <= 3'h0;
        end
        else if (ce && wr_en)
        begin
            if (hit_scc)
                scc_reg <= pwdata[7:0] & SCSS_SCC_WMASK;
            if (hit_int_fast_rc_control_reg)
                int_fast_rc_control_reg_reg <= int_fast_rc_control_reg_next;
            if (hit_lxtc)
                lxtc_reg <= {pwdata[SCSS_XTPIN_BIT], 1'b0, pwdata[SCSS_SLOW_CRYSTAL_ENABLE_BIT]};
        end
    end

    // Start-up delay counted in slow crystal periods
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lxt_cnt_reg <= 10'h000;
            lxt_rdy_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (!lxt_run)
            begin
                lxt_cnt_reg <= 10'h000;
                lxt_rdy_reg <= 1'b0;
            end
            else if (lxt_tick && !lxt_rdy_reg)
            begin
                lxt_cnt_reg <= lxt_cnt_reg + 10'h001;
                lxt_rdy_reg <= lxt_cnt_reg == SCSS_LXT_START;
            end
        end
    end

    // Active selection and divider; first new-source tick only resyncs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            act_cks_reg <= SCSS_SCC_RST[SCSS_CKS_LSB +: 3];
            act_fhs_reg <= SCSS_SCC_RST[SCSS_FHS_BIT];
            act_fss_reg <= 1'b0;
            sync_reg    <= 1'b0;
            cnt_reg     <= 6'h00;
        end
        else if (ce)
        begin
            if (apply_sw)
            begin
                act_cks_reg <= cks;
                act_fhs_reg <= fast_source_select;
                act_fss_reg <= fss_eff;
                sync_reg    <= 1'b1;
            end
            else if (src_tick && sync_reg)
                sync_reg <= 1'b0;
            else if (src_tick)
                cnt_reg <= div_wrap ? 6'h00 : cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_en_reg  <= 1'b0;
            wdt_en_reg  <= 1'b0;
            tb_en_reg   <= 1'b0;
            hxt_en_reg  <= 1'b0;
            int_fast_rc_osc_en_reg <= 1'b1;
            lxt_en_reg  <= 1'b0;
        end
        else if (ce)
        begin
            sys_en_reg  <= sys_pulse & ~cpu_halt;
            wdt_en_reg  <= int_slow_rc_osc_tick;
            tb_en_reg   <= fsub_tick & slow_keep;
            hxt_en_reg  <= (act_fhs_reg == SCSS_FAST_HXT) & fast_keep;
            int_fast_rc_osc_en_reg <= ((act_fhs_reg != SCSS_FAST_HXT) | int_fast_rc_control_reg_reg[SCSS_HIRCEN_BIT])
                           & fast_keep;
            lxt_en_reg  <= lxt_run;
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign sys_clk_en  = sys_en_reg;
    assign wdt_clk_en  = wdt_en_reg;
    assign tb_clk_en   = tb_en_reg;
    assign hxt_en      = hxt_en_reg;
    assign int_fast_rc_osc_en     = int_fast_rc_osc_en_reg;
    assign int_fast_rc_osc_freq   = int_fast_rc_control_reg_reg[SCSS_HFREQ_LSB +: 2];
    assign lxt_en      = lxt_en_reg;
    assign xt_pins_osc = lxtc_reg[SCSS_XTPIN_BIT];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_src_fast;
        ce && !slow_mode |-> src_tick == ((act_fhs_reg == SCSS_FAST_HXT) ? hxt_tick : int_fast_rc_osc_tick);
    endproperty
    a_src_fast: assert property (p_src_fast) else $error("fast source mismatch");

    property p_src_slow;
        ce && slow_mode && !fsub_lxt |-> src_tick == int_slow_rc_osc_tick;
    endproperty
    a_src_slow: assert property (p_src_slow) else $error("slow source mismatch");

    property p_lxt_usable;
        ce && slow_mode && act_fss_reg && !lxt_rdy_reg |-> fsub_tick == int_slow_rc_osc_tick;
    endproperty
    a_lxt_usable: assert property (p_lxt_usable) else $error("slow path without osc");

    property p_hfreq_legal;
        int_fast_rc_control_reg_reg[SCSS_HFREQ_LSB +: 2] != SCSS_HFREQ_BAD;
    endproperty
    a_hfreq_legal: assert property (p_hfreq_legal) else $error("illegal rc freq");

    property p_lxt_start;
        ce && $rose(lxt_rdy_reg) |-> $past(lxt_cnt_reg) == SCSS_LXT_START && $past(lxt_run);
    endproperty
    a_lxt_start: assert property (p_lxt_start) else $error("early crystal ready");

    property p_pins;
        lxt_en_reg |-> ##0 $past(lxtc_reg[SCSS_XTPIN_BIT]) || !ce;
    endproperty
    a_pins: assert property (p_pins) else $error("crystal without pins");

    property p_wdt;
        ce |=> wdt_en_reg == $past(int_slow_rc_osc_tick);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog clock lost");

    property p_halt;
        ce && cpu_halt |=> !sys_en_reg ##0 (tb_en_reg == $past(fsub_tick & slow_keep));
    endproperty
    a_halt: assert property (p_halt) else $error("halt clock wrong");

    property p_ratio;
        ce && sys_pulse && !slow_mode |=> cnt_reg == 6'h00;
    endproperty
    a_ratio: assert property (p_ratio) else $error("divider ratio wrong");

    property p_switch;
        ce && apply_sw |=> sync_reg && cnt_reg == 6'h00;
    endproperty
    a_switch: assert property (p_switch) else $error("switch without resync");

    c_slow:   cover property (ce && slow_mode && sys_pulse);
    c_div64:  cover property (ce && act_cks_reg == 3'h6 && sys_pulse);
    c_lxtrdy: cover property ($rose(lxt_rdy_reg));
    c_switch: cover property (ce && apply_sw);
endmodule

// [rtl/scss_pkg.sv]
package scss_pkg;
    // Register byte offsets.
    localparam logic [11:0] SCSS_SCC_OFF    = 12'h000;
    localparam logic [11:0] SCSS_INT_FAST_RC_CONTROL_REG_OFF  = 12'h004;
    localparam logic [11:0] SCSS_LXTC_OFF   = 12'h008;
    localparam logic [11:0] SCSS_STAT_OFF   = 12'h00c;
    // system_clock_control_reg fields.
    localparam int          SCSS_CKS_LSB    = 5;
    localparam int          SCSS_FHS_BIT    = 3;
    localparam int          SCSS_FSS_BIT    = 2;
    localparam int          SCSS_FHIDEN_BIT = 1;
    localparam int          SCSS_FSIDEN_BIT = 0;
    localparam logic [7:0]  SCSS_SCC_RST    = 8'h00;
    localparam logic [7:0]  SCSS_SCC_WMASK  = 8'hef;
    // int_fast_rc_control_reg fields.
    localparam int          SCSS_HFREQ_LSB  = 2;
    localparam int          SCSS_HIRCEN_BIT = 0;
    localparam logic [3:0]  SCSS_INT_FAST_RC_CONTROL_REG_RST  = 4'h1;
    localparam logic [1:0]  SCSS_HFREQ_8M   = 2'h0;
    localparam logic [1:0]  SCSS_HFREQ_12M  = 2'h1;
    localparam logic [1:0]  SCSS_HFREQ_16M  = 2'h2;
    localparam logic [1:0]  SCSS_HFREQ_BAD  = 2'h3;
    // Slow crystal control fields.
    localparam int          SCSS_SLOW_CRYSTAL_ENABLE_BIT  = 0;
    localparam int          SCSS_LXTRDY_BIT = 1;
    localparam int          SCSS_XTPIN_BIT  = 2;
    // Selection encodings and the slow path mode code.
    localparam logic        SCSS_FAST_HXT   = 1'b1;
    localparam logic        SCSS_SLOW_LXT   = 1'b1;
    localparam logic [2:0]  SCSS_CKS_SLOW   = 3'h7;
    // Slow crystal start-up, in slow crystal periods.
    localparam logic [9:0]  SCSS_LXT_START  = 10'h3ff;
endpackage

// [rtl/scss_osc_tick.sv]
`timescale 1ns/10ps
// Turns a free-running oscillator into a one-cycle tick per rising edge.
module scss_osc_tick
    import scss_pkg::*;
(
    input  wire logic pclk,     // Bus clock
    input  wire logic presetn,  // Asynchronous reset
    input  wire logic ce,       // Clock enable
    input  wire logic osc_in,   // Asynchronous oscillator output
    output logic      tick      // One pulse per oscillator rising edge
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic tick_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
            tick_reg  <= 1'b0;
        end
        else if (ce)
        begin
            sync1_reg <= osc_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            tick_reg  <= sync2_reg & ~prev_reg;
        end
    end

    assign tick = tick_reg;
endmodule

// [sim/scss_osc_model.sv]
`timescale 1ns/10ps
module scss_osc_model
(
    input  wire logic       hxt_en,      // Fast crystal enable
    input  wire logic       int_fast_rc_osc_en,     // Fast RC enable
    input  wire logic [1:0] int_fast_rc_osc_freq,   // Fast RC trim select
    input  wire logic       lxt_en,      // Slow crystal enable
    input  wire logic       xt_pins_osc, // Slow crystal pins in oscillator mode
    output logic            ext_fast_crystal_osc,         // Fast crystal wave
    output logic            int_fast_rc_osc,        // Fast RC wave
    output logic            ext_slow_crystal_osc,         // Slow crystal wave
    output logic            int_slow_rc_osc         // Slow RC wave
);
    // Periods are scaled down so that crystal start-up fits a short run.
    // four oscillators
    initial {ext_fast_crystal_osc, int_fast_rc_osc, ext_slow_crystal_osc, int_slow_rc_osc} = 4'h0;
    always #70 if (hxt_en) ext_fast_crystal_osc = ~ext_fast_crystal_osc;
    always #(int_fast_rc_osc_freq == 2'h2 ? 45 : int_fast_rc_osc_freq == 2'h1 ? 60 : 90) if (int_fast_rc_osc_en) int_fast_rc_osc = ~int_fast_rc_osc;
    always #100 if (lxt_en && xt_pins_osc) ext_slow_crystal_osc = ~ext_slow_crystal_osc;
    always #130 int_slow_rc_osc = ~int_slow_rc_osc;
endmodule

// [sim/tb.sv]
`timescale 1ns/10ps
module tb
    import scss_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        cpu_halt = 0, counting = 0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, sys_clk_en, wdt_clk_en, tb_clk_en;
    logic        hxt_en, int_fast_rc_osc_en, lxt_en, xt_pins_osc, ext_fast_crystal_osc, int_fast_rc_osc, ext_slow_crystal_osc, int_slow_rc_osc;
    logic [1:0]  int_fast_rc_osc_freq;
    logic [3:0]  osc_q = 4'h0;
    wire  [3:0]  osc = {int_slow_rc_osc, ext_slow_crystal_osc, int_fast_rc_osc, ext_fast_crystal_osc};
    int          fail_count = 0, n_tests = 0, n_sys, n_wdt, n_tb, gap, min_gap;
    int          n_osc [4];

    always #10 pclk = ~pclk;

    scss_top uut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hxt_osc_in(ext_fast_crystal_osc), .int_fast_rc_osc_osc_in(int_fast_rc_osc), .lxt_osc_in(ext_slow_crystal_osc),
        .int_slow_rc_osc_osc_in(int_slow_rc_osc), .cpu_halt, .sys_clk_en, .wdt_clk_en, .tb_clk_en, .hxt_en,
        .int_fast_rc_osc_en, .int_fast_rc_osc_freq, .lxt_en, .xt_pins_osc);

    scss_osc_model osc_model (.hxt_en, .int_fast_rc_osc_en, .int_fast_rc_osc_freq, .lxt_en, .xt_pins_osc,
        .ext_fast_crystal_osc, .int_fast_rc_osc, .ext_slow_crystal_osc, .int_slow_rc_osc);

    always @(posedge pclk)
    begin
        if (counting)
        begin
            n_sys += int'(sys_clk_en);
            n_wdt += int'(wdt_clk_en);
            n_tb += int'(tb_clk_en);
            for (int i = 0; i < 4; i++)
                n_osc[i] += int'(osc[i] & !osc_q[i]);
            gap++;
            if (sys_clk_en === 1'b1)
            begin
                if (gap >= 0 && gap < min_gap)
                    min_gap = gap;
                gap = 0;
            end
        end
        osc_q <= osc;
    end

    task complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
        end
    endtask

    task near(input string s, input int e, input int g, input int t);
        n_tests++;
        if (g > e + t || g < e - t)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", s, e, g);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50)
        begin
            fail_count++;
            $display("CHECK FAILED pready expected 1 seen 0");
            complete_run();
        end
    endtask

    task cnt_on();
        @(negedge pclk);
        n_sys = 0;
        n_wdt = 0;
        n_tb = 0;
        n_osc = '{4{0}};
        gap = -1000000;
        min_gap = 1000000;
        counting = 1;
    endtask

    task win(input int c);
        cnt_on();
        repeat (c) @(negedge pclk);
        counting = 0;
    endtask

    task t_reset();
        apb(1'b0, SCSS_SCC_OFF, 32'h0);
        chk("scc", 32'h0, rd);
        apb(1'b0, SCSS_INT_FAST_RC_CONTROL_REG_OFF, 32'h0);
        chk("int_fast_rc_control_reg", 32'h1, rd);
        chk("int_fast_rc_osc_en", 32'h1, 32'(int_fast_rc_osc_en));
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped slverr", 32'h1, 32'(er));
    endtask

    task t_freq();
        logic [1:0] e;
        e = 2'h0;
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, SCSS_INT_FAST_RC_CONTROL_REG_OFF, 32'(c * 4 + 1));
            if (c != 3)
                e = 2'(c);
            repeat (2) @(posedge pclk);
            chk("int_fast_rc_osc_freq", 32'(e), 32'(int_fast_rc_osc_freq));
        end
        apb(1'b1, SCSS_INT_FAST_RC_CONTROL_REG_OFF, 32'h1);
    endtask

    task t_div();
        for (int k = 0; k < 7; k++)
        begin
            apb(1'b1, SCSS_SCC_OFF, 32'(k << 5));
            repeat (800) @(posedge pclk);
            win(3000);
            near("sys div", n_osc[1] >> k, n_sys, 2);
        end
    endtask

    task t_fast_xt();
        cnt_on();
        apb(1'b1, SCSS_SCC_OFF, 32'h8);
        repeat (2000) @(negedge pclk);
        counting = 0;
        near("switch min gap", 7, min_gap, 2);
        chk("hxt_en", 32'h1, 32'(hxt_en));
        apb(1'b0, SCSS_STAT_OFF, 32'h0);
        chk("active fhs", 32'h1, 32'(rd[3]));
        win(2000);
        near("sys hxt", n_osc[0], n_sys, 2);
    endtask

    task t_slow();
        apb(1'b1, SCSS_SCC_OFF, 32'he0);
        repeat (800) @(posedge pclk);
        win(3000);
        near("sys int_slow_rc_osc", n_osc[3], n_sys, 2);
        near("tb int_slow_rc_osc", n_osc[3], n_tb, 2);
        apb(1'b1, SCSS_SCC_OFF, 32'he4);
        repeat (100) @(posedge pclk);
        apb(1'b0, SCSS_STAT_OFF, 32'h0);
        chk("active fss", 32'h0, 32'(rd[2]));
        win(3000);
        near("sys fallback", n_osc[3], n_sys, 2);
    endtask

    task t_lxt();
        time t0;
        int i;
        apb(1'b1, SCSS_LXTC_OFF, 32'h5);
        t0 = $time;
        apb(1'b0, SCSS_LXTC_OFF, 32'h0);
        chk("lxt ready early", 32'h0, 32'(rd[1]));
        chk("lxt_en", 32'h1, 32'(lxt_en));
        chk("xt_pins_osc", 32'h1, 32'(xt_pins_osc));
        for (i = 0; i < 300; i++)
        begin
            repeat (100) @(posedge pclk);
            apb(1'b0, SCSS_LXTC_OFF, 32'h0);
            if (rd[1] === 1'b1)
                break;
        end
        if (i == 300)
        begin
            fail_count++;
            $display("CHECK FAILED lxt ready expected 1 seen 0");
            complete_run();
        end
        chk("lxt start time", 32'h1, 32'($time - t0 >= 204800));
        repeat (800) @(posedge pclk);
        apb(1'b0, SCSS_STAT_OFF, 32'h0);
        chk("active fss", 32'h1, 32'(rd[2]));
        win(3000);
        near("sys lxt", n_osc[2], n_sys, 2);
    endtask

    task t_halt();
        apb(1'b1, SCSS_SCC_OFF, 32'he0);
        repeat (800) @(posedge pclk);
        cpu_halt <= 1'b1;
        win(3000);
        chk("tb in sleep", 32'h0, 32'(n_tb));
        near("wdt in sleep", n_osc[3], n_wdt, 2);
        apb(1'b1, SCSS_SCC_OFF, 32'he1);
        win(3000);
        near("tb in idle", n_osc[3], n_tb, 2);
        cpu_halt <= 1'b0;
    endtask

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_freq();
        t_div();
        t_fast_xt();
        t_slow();
        t_lxt();
        t_halt();
        complete_run();
    end
endmodule
